/* File: adc_result_regs.sv */
// converter result registers, status flags and interrupt mask on apb
// assumes a converter core that pulses one completed conversion per cycle
// at most, and a receive dma that reports its two buffer levels
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "adc_result_map.svh"

////////////////////////////////////////////////////////////////////////////
//
// Behaviour
// - last result held until next completion
// - channel result written only when channel enabled
// - enable-set write of one sets mask bit
// - enable-clear write of one clears mask bit
// - mask readable, ones for enabled sources
// - one shared twenty-bit source layout
// - result available set on completion, cleared by read
// - channel overrun sticky until status read
// - channel done only while enabled and finished
module adc_result_regs
    import adc_result_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter int RES_W = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter core and receive dma
    input wire conv_event_t conv_done,
    input wire logic [7:0] channel_enabled,
    input wire logic receive_count_reached_zero,
    input wire logic receive_buffers_exhausted,
    // interrupt
    output logic irq
);

    // layout is fixed at eight channels of ten bits
    if (NUM_CH != 8 || RES_W != 10) begin : g_bad_param
        $error("adc_result_regs serves only NUM_CH=8 and RES_W=10");
    end

    ////////////////////////////////////////////////////////////////////////
    // state

    apb_resp_t resp_r, resp_nxt;
    src_vec_t snap_r, snap_nxt;
    src_vec_t mask_r, mask_nxt;
    logic [RES_W-1:0] last_result_value_r, last_result_value_nxt;
    logic [NUM_CH-1:0][RES_W-1:0] ch_result_r, ch_result_nxt;
    logic [NUM_CH-1:0] channel_conversion_done_r, channel_conversion_done_nxt;
    logic [NUM_CH-1:0] channel_overrun_r, channel_overrun_nxt;
    logic result_available_r, result_available_nxt;
    logic any_channel_overrun_r, any_channel_overrun_nxt;
    logic rx_end_r, rx_full_r;
    logic irq_r, irq_nxt;
    src_vec_t status;
    src_vec_t status_nxt;
    src_vec_t clr_vec;
    logic setup, wr_done, rd_done, ev, ev_en;

    // byte address of a channel result register
    function automatic logic is_ch_result(input logic [7:0] a);
        logic [7:0] top;
        top = 8'(`OFS_CH_RESULT0 + 4 * (NUM_CH - 1));
        return (a >= `OFS_CH_RESULT0) && (a <= top) && (a[1:0] == 2'h0);
    endfunction

    // status word in the shared source layout
    function automatic src_vec_t pack_status(input logic [7:0] done,
            input logic [7:0] ovr, input logic avail, input logic govr,
            input logic rx_end, input logic rx_full);
        return {rx_full, rx_end, govr, avail, ovr, done};
    endfunction

    assign setup = psel & ~penable;
    assign wr_done = psel & penable & resp_r.ready & pwrite;
    assign rd_done = psel & penable & resp_r.ready & ~pwrite;
    assign ev = conv_done.valid;
    assign ev_en = ev & channel_enabled[conv_done.channel];
    assign status = pack_status(channel_conversion_done_r, channel_overrun_r,
        result_available_r, any_channel_overrun_r, rx_end_r, rx_full_r);

    ////////////////////////////////////////////////////////////////////////
    // bus answer: data is captured in setup, so access ends with no wait

    // snapshot records which flags the reader saw; only those get cleared,
    // so an event landing between setup and access is never lost
    always_comb begin
        logic [2:0] idx;
        idx = 3'((paddr - `OFS_CH_RESULT0) >> 2);
        resp_nxt = '{ready: setup, slverr: 1'b0, rdata: `RST_RDATA};
        snap_nxt = snap_r;
        if (setup) begin
            snap_nxt = '0;
            unique case (paddr)
                `OFS_STATUS: begin
                    resp_nxt.rdata = 32'(status);
                    snap_nxt = status & `STATUS_CLR_MASK;
                end
                `OFS_LAST: begin
                    resp_nxt.rdata = 32'(last_result_value_r);
                    snap_nxt[`BIT_AVAIL] = result_available_r;
                end
                `OFS_IEN_STATE: resp_nxt.rdata = 32'(mask_r);
                `OFS_IEN_SET, `OFS_IEN_CLR: resp_nxt.rdata = `RST_RDATA;
                default: begin
                    if (is_ch_result(paddr)) begin
                        resp_nxt.rdata = 32'(ch_result_r[idx]);
                        snap_nxt[idx] = channel_conversion_done_r[idx];
                    end else begin
                        resp_nxt.slverr = 1'b1; // unmapped address
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_r <= '{ready: 1'b0, slverr: 1'b0, rdata: `RST_RDATA};
            snap_r <= '0;
        end else begin
            resp_r <= resp_nxt;
            snap_r <= snap_nxt;
        end
    end

    assign prdata = resp_r.rdata;
    assign pready = resp_r.ready;
    assign pslverr = resp_r.slverr;

    ////////////////////////////////////////////////////////////////////////
    // interrupt mask: set and clear words only, never written directly

    always_comb begin
        mask_nxt = mask_r;
        if (wr_done && paddr == `OFS_IEN_SET) begin
            mask_nxt = mask_r | pwdata[`SRC_W-1:0];
        end
        if (wr_done && paddr == `OFS_IEN_CLR) begin
            mask_nxt = mask_r & ~pwdata[`SRC_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // results: last one always, per channel only when enabled

    always_comb begin
        last_result_value_nxt = last_result_value_r;
        ch_result_nxt = ch_result_r;
        if (ev) begin
            last_result_value_nxt = conv_done.data;
        end
        if (ev_en) begin
            ch_result_nxt[conv_done.channel] = conv_done.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_result_value_r <= `RST_RESULT;
            ch_result_r <= '0;
        end else begin
            last_result_value_r <= last_result_value_nxt;
            ch_result_r <= ch_result_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags: set wins over clear everywhere

    // clears come from completed reads plus a write of one to status
    always_comb begin
        clr_vec = rd_done ? snap_r : '0;
        if (wr_done && paddr == `OFS_STATUS) begin
            clr_vec = clr_vec | (pwdata[`SRC_W-1:0] & `STATUS_CLR_MASK);
        end
    end

    // overrun means a new result lands on one nobody has read yet
    always_comb begin
        logic [NUM_CH-1:0] set_done;
        set_done = '0;
        if (ev_en) begin
            set_done[conv_done.channel] = 1'b1;
        end
        channel_conversion_done_nxt = ((channel_conversion_done_r
            & ~clr_vec[`BIT_DONE_LO +: NUM_CH]) | set_done)
            & channel_enabled;
        channel_overrun_nxt = (channel_overrun_r
            & ~clr_vec[`BIT_OVR_LO +: NUM_CH])
            | (set_done & channel_conversion_done_r);
        result_available_nxt = (result_available_r & ~clr_vec[`BIT_AVAIL])
            | ev;
        any_channel_overrun_nxt = (any_channel_overrun_r
            & ~clr_vec[`BIT_GOVR]) | (ev & result_available_r);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_conversion_done_r <= '0;
            channel_overrun_r <= '0;
            result_available_r <= 1'b0;
            any_channel_overrun_r <= 1'b0;
            rx_end_r <= 1'b0;
            rx_full_r <= 1'b0;
        end else begin
            channel_conversion_done_r <= channel_conversion_done_nxt;
            channel_overrun_r <= channel_overrun_nxt;
            result_available_r <= result_available_nxt;
            any_channel_overrun_r <= any_channel_overrun_nxt;
            rx_end_r <= receive_count_reached_zero; // dma levels, not sticky
            rx_full_r <= receive_buffers_exhausted;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: built from next values so it tracks flags with no lag

    always_comb begin
        status_nxt = pack_status(channel_conversion_done_nxt,
            channel_overrun_nxt, result_available_nxt,
            any_channel_overrun_nxt, receive_count_reached_zero,
            receive_buffers_exhausted);
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    last_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev |=> last_result_value_r == $past(conv_done.data))
        else $error("last result not loaded on completion");

    disabled_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev && !ev_en |=> $stable(ch_result_r))
        else $error("channel result changed for disabled channel");

    mask_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && paddr == `OFS_IEN_SET |=>
        mask_r == ($past(mask_r) | $past(pwdata[`SRC_W-1:0])))
        else $error("enable-set write did not set mask bits");

    mask_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && paddr == `OFS_IEN_CLR |=>
        (mask_r & $past(pwdata[`SRC_W-1:0])) == '0
        && mask_r == ($past(mask_r) & ~$past(pwdata[`SRC_W-1:0])))
        else $error("enable-clear write did not clear mask bits");

    mask_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && paddr == `OFS_IEN_STATE |=>
        prdata == 32'($past(mask_r)) ##1 $stable(mask_r))
        else $error("mask read returned wrong value");

    status_layout_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && paddr == `OFS_STATUS |=>
        prdata[`BIT_AVAIL] == $past(result_available_r)
        && prdata[`BIT_GOVR] == $past(any_channel_overrun_r)
        && prdata[`BIT_OVR_LO +: 8] == $past(channel_overrun_r)
        && prdata[`BIT_DONE_LO +: 8] == $past(channel_conversion_done_r)
        && prdata[31:`SRC_W] == '0)
        else $error("status word fields misplaced");

    avail_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev |=> result_available_r)
        else $error("result available not set on completion");

    avail_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && paddr == `OFS_LAST && snap_r[`BIT_AVAIL] && !ev
        |=> !result_available_r)
        else $error("result available not cleared by last-result read");

    ovr_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && paddr == `OFS_STATUS && !ev |=>
        (channel_overrun_r & $past(snap_r[`BIT_OVR_LO +: 8])) == '0)
        else $error("channel overrun survived status read");

    done_enabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (channel_conversion_done_r & ~$past(channel_enabled)) == '0)
        else $error("done flag set on disabled channel");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(status & mask_r))
        else $error("interrupt not equal to masked status");

    // per-channel result load, the counterpart of disabled_keep_a
    ch_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev_en |=> ch_result_r[$past(conv_done.channel)] == $past(conv_done.data))
        else $error("enabled channel result not written");

    // a direct write to the mask word must not leak into the mask
    mask_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && paddr == `OFS_IEN_STATE |=> $stable(mask_r))
        else $error("mask state changed by direct write");

    ovr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev_en && channel_conversion_done_r[conv_done.channel]
        |=> channel_overrun_r[$past(conv_done.channel)])
        else $error("overrun not flagged on unread channel result");

    govr_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev && result_available_r |=> any_channel_overrun_r)
        else $error("general overrun not flagged");

    // only flags seen at setup are cleared, so a racing set may survive
    done_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_done && is_ch_result(paddr) && !ev |=>
        (channel_conversion_done_r & $past(snap_r[`BIT_DONE_LO +: 8])) == '0)
        else $error("done flag survived channel result read");

    conv_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        ev_en ##1 rd_done && paddr == `OFS_LAST);
    overrun_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        ev_en ##[1:20] ev_en && channel_overrun_nxt != '0);
    irq_rise_c: cover property (@(posedge pclk) disable iff (!presetn)
        !irq ##1 irq);
    status_read_c: cover property (@(posedge pclk) disable iff (!presetn)
        rd_done && paddr == `OFS_STATUS && snap_r != '0);

endmodule

/* File: adc_result_map.svh */
// register offsets, field positions and reset values for the converter
// result and interrupt-mask block; included by the block and its bench
`ifndef ADC_RESULT_MAP_SVH
`define ADC_RESULT_MAP_SVH

// byte offsets on the peripheral bus
`define OFS_STATUS 8'h1C
`define OFS_LAST 8'h20
`define OFS_IEN_SET 8'h24
`define OFS_IEN_CLR 8'h28
`define OFS_IEN_STATE 8'h2C
`define OFS_CH_RESULT0 8'h30

// shared layout of status, enable, disable and mask words
`define SRC_W 20
`define BIT_DONE_LO 0
`define BIT_OVR_LO 8
`define BIT_AVAIL 16
`define BIT_GOVR 17
`define BIT_RX_END 18
`define BIT_RX_FULL 19

// status bits that a status read (or a write of one) clears
`define STATUS_CLR_MASK 20'h2FF00

// reset values
`define RST_MASK 20'h00000
`define RST_RESULT 10'h000
`define RST_RDATA 32'h00000000

`endif

/* File: adc_result_pkg.sv */
// types shared by the result block and its bench
// assumes the offsets and field positions come from adc_result_map.svh
package adc_result_pkg;

    // one completed conversion from the converter core
    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        logic [9:0] data;
    } conv_event_t;

    // interrupt source vector, status / mask layout
    typedef logic [19:0] src_vec_t;

    // apb answer carried as one bundle
    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } apb_resp_t;

endpackage

/* File: adc_result_regs_tb.sv */
// self-checking bench for the converter result and interrupt-mask block
// assumes zero-wait apb answers and at most one conversion pulse per cycle
`timescale 1ns/1ps
`include "adc_result_map.svh"

module adc_result_regs_tb
    import adc_result_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rx_end, rx_full;
    logic [7:0] paddr, channel_enabled;
    logic [31:0] pwdata, prdata, v, w, r;
    logic e;
    conv_event_t conv_done;
    int errors, checked;
    logic [15:0] seed;
    // reference copy of the block state
    src_vec_t mask_m;
    logic [7:0] done_m, ovr_m;
    logic avail_m, govr_m, rxe_m, rxf_m;
    logic [9:0] last_m;
    logic [9:0] res_m [8];

    adc_result_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done), .channel_enabled(channel_enabled),
        .receive_count_reached_zero(rx_end), .receive_buffers_exhausted(rx_full), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // a hung handshake ends the run as a failure
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        $display("Error %0t: run timed out", $time);
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [15:0] lfsr_f(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
    endfunction

    task automatic rnd(output logic [31:0] x);
        seed = lfsr_f(seed);
        x[15:0] = seed;
        seed = lfsr_f(seed);
        x[31:16] = seed;
    endtask

    // expected status word; done bits only show for enabled channels
    function automatic src_vec_t status_f();
        return {rxf_m, rxe_m, govr_m, avail_m, ovr_m, done_m & channel_enabled};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd_v, output logic er);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // if pready never comes, only the watchdog ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next request never lands in the same time step
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic er;
        apb(1'b0, a, 32'h00000000, x, er);
        chk(x, exp);
        chk({31'h0, er}, 32'h00000000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic er;
        apb(1'b1, a, d, x, er);
    endtask

    task automatic rd_status();
        rd(`OFS_STATUS, {12'h000, status_f()});
        ovr_m = 8'h00;
        govr_m = 1'b0;
    endtask

    task automatic rd_last();
        rd(`OFS_LAST, {22'h000000, last_m});
        avail_m = 1'b0;
    endtask

    task automatic rd_ch(input logic [2:0] n);
        rd(`OFS_CH_RESULT0 + {3'h0, n, 2'b00}, {22'h000000, res_m[n]});
        done_m[n] = 1'b0;
    endtask

    // k completions back to back on one channel
    task automatic conv(input logic [2:0] ch, input int k);
        logic [31:0] x;
        repeat (k) begin
            rnd(x);
            conv_done <= '{1'b1, ch, x[9:0]};
            @(posedge pclk);
            last_m = x[9:0];
            govr_m = govr_m | avail_m;
            avail_m = 1'b1;
            if (channel_enabled[ch]) begin
                ovr_m[ch] = ovr_m[ch] | done_m[ch];
                done_m[ch] = 1'b1;
                res_m[ch] = x[9:0];
            end
        end
        conv_done <= '0;
        @(posedge pclk);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, rx_end, rx_full} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        conv_done = '0;
        errors = 0;
        checked = 0;
        seed = 16'h004A;
        {mask_m, done_m, ovr_m, avail_m, govr_m, rxe_m, rxf_m, last_m} = '0;
        for (int i = 0; i < 8; i++)
            res_m[i] = 10'h000;
        rnd(v);
        // channel 0 always on, channel 7 always off
        channel_enabled = {1'b0, v[6:1], 1'b1};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_IEN_STATE, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        // unmapped word answers with an error and zero data
        apb(1'b0, 8'h50, 32'h00000000, r, e);
        chk(r, 32'h00000000);
        chk({31'h0, e}, 32'h00000001);
        // every bit set, upper bits ignored, direct write ignored
        wr(`OFS_IEN_SET, 32'hFFFFFFFF);
        mask_m = 20'hFFFFF;
        rd(`OFS_IEN_STATE, {12'h000, mask_m});
        wr(`OFS_IEN_STATE, 32'h00000000);
        rd(`OFS_IEN_STATE, {12'h000, mask_m});
        chk({31'h0, irq}, 32'h00000000);
        wr(`OFS_IEN_CLR, 32'hFFFFFFFF);
        mask_m = '0;
        rd(`OFS_IEN_STATE, 32'h00000000);
        // back-to-back completions, then a disabled channel
        conv(3'h0, 2);
        conv(3'h7, 1);
        wr(`OFS_LAST, 32'h000003FF);
        rd_ch(3'h7);
        rd_status();
        rd_last();
        // write-one-to-clear of the overrun bits
        conv(3'h0, 2);
        wr(`OFS_STATUS, 32'hFFFFFFFF);
        ovr_m = 8'h00;
        govr_m = 1'b0;
        rd_status();
        // random traffic; mixes mask, conversion, reads and receive levels
        for (int i = 0; i < 300; i++) begin
            rnd(v);
            rnd(w);
            case (v[2:0])
                3'h0: begin
                    wr(`OFS_IEN_SET, w);
                    mask_m = mask_m | w[19:0];
                    rd(`OFS_IEN_STATE, {12'h000, mask_m});
                end
                3'h1: begin
                    wr(`OFS_IEN_CLR, w);
                    mask_m = mask_m & ~w[19:0];
                    rd(`OFS_IEN_STATE, {12'h000, mask_m});
                end
                3'h2, 3'h3: conv(w[2:0], 1 + int'(v[3]));
                3'h4: rd_status();
                3'h5: rd_last();
                3'h6: rd_ch(w[2:0]);
                default: begin
                    rx_end <= w[0];
                    rx_full <= w[1];
                    channel_enabled <= {1'b0, w[8:3], 1'b1};
                    repeat (2) @(posedge pclk);
                    rxe_m = w[0];
                    rxf_m = w[1];
                    done_m = done_m & channel_enabled;
                end
            endcase
            chk({31'h0, irq}, {31'h0, |(status_f() & mask_m)});
        end
        // mid-run reset with every source unmasked must clear the mask
        wr(`OFS_IEN_SET, 32'h000FFFFF);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        {mask_m, done_m, ovr_m, avail_m, govr_m, last_m} = '0;
        @(posedge pclk);
        rd(`OFS_IEN_STATE, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        rd_status();
        rd_last();
        print_verdict();
    end
endmodule
